// >>> design/trcc_cfg.svh
// Command codes, field positions, reset values and latencies of the region bank.
`ifndef TRCC_CFG_SVH
`define TRCC_CFG_SVH

// Command codes of the bank on the management port.
`define TRCC_CMD_BOUND3 8'h21
`define TRCC_CMD_BOUND4 8'h22
`define TRCC_CMD_BOUND5 8'h23
`define TRCC_CMD_BOUND6 8'h24
`define TRCC_CMD_VWARM 8'h25
`define TRCC_CMD_VMID 8'h26
`define TRCC_CMD_IWARM 8'h27
`define TRCC_CMD_CFG 8'h29

// Reset values.
`define TRCC_RST_BOUND3 16'h1F22
`define TRCC_RST_BOUND4 16'h1BC8
`define TRCC_RST_BOUND5 16'h18B5
`define TRCC_RST_BOUND6 16'h136A
`define TRCC_RST_VWARM 10'h067
`define TRCC_RST_VMID 15'h1DEF
`define TRCC_RST_IWARM 10'h1EF
`define TRCC_RST_CFG 3'h1

// Field positions: low bit of each packed five-bit code, and the enable bit of the config register.
`define TRCC_FLD_LO 0
`define TRCC_FLD_HI 5
`define TRCC_FLD_TOP 10
`define TRCC_CFG_EN_BIT 0

// Cycles from a register write or a new reading to the applied codes.
`define TRCC_APPLY_LATENCY 2

`endif

// >>> design/trcc_code_mux.sv
// Chooses the charge voltage and current codes for the active region.
`default_nettype none
module trcc_code_mux (
	input wire logic clock,
	input wire logic nrst,
	input wire logic enable,
	input wire logic [2:0] region,
	input wire trcc_pkg::trcc_codes_s codes,
	input wire logic [4:0] base_vcode,
	input wire logic [4:0] base_icode,
	input wire logic thermal_active,
	input wire logic [4:0] thermal_icode,
	output trcc_pkg::trcc_applied_s applied
);

	typedef struct packed {
		trcc_pkg::trcc_applied_s applied;
	} trcc_mux_state_s;

	trcc_mux_state_s state_q;
	trcc_mux_state_s state_d;
	logic [4:0] reg_v;
	logic [4:0] reg_i;
	logic in_table;
	logic [4:0] cur;

	// Lower of two current codes; thermal regulation may only reduce current.
	function automatic logic [4:0] trcc_min5(input logic [4:0] a,
		input logic [4:0] b);
		trcc_min5 = (a < b) ? a : b;
	endfunction

	// Regions 1 and 7 carry no regional code; the charger's own
	// temperature fault logic decides what happens there.
	always_comb begin
		reg_v = base_vcode;
		reg_i = base_icode;
		in_table = 1'b1;
		unique case (trcc_pkg::trcc_region_e'(region))
			trcc_pkg::TRCC_R2: begin
				reg_v = codes.v2;
				reg_i = codes.i2;
			end
			trcc_pkg::TRCC_R3: begin
				reg_v = codes.v3;
				reg_i = codes.i3;
			end
			trcc_pkg::TRCC_R4: begin
				reg_v = codes.v4;
				reg_i = codes.i4;
			end
			trcc_pkg::TRCC_R5: begin
				reg_v = codes.v5;
				reg_i = codes.i5;
			end
			trcc_pkg::TRCC_R6: begin
				reg_v = codes.v6;
				reg_i = codes.i6;
			end
			default: begin
				in_table = 1'b0;
			end
		endcase
	end

	// Substitute only while enabled; otherwise base voltage passes through and base current, capped by thermal_icode while thermal_active.
	always_comb begin
		state_d = state_q;
		state_d.applied.subst = enable && in_table;
		state_d.applied.vcode = state_d.applied.subst ? reg_v :
			base_vcode;
		cur = state_d.applied.subst ? reg_i : base_icode;
		state_d.applied.icode = thermal_active ?
			trcc_min5(cur, thermal_icode) : cur;
	end

	// Codes are registered so the servo DACs see glitch-free steps.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign applied = state_q.applied;

endmodule
`default_nettype wire

// >>> design/trcc_pkg.sv
// Types shared by the temperature-region charge configuration block.
`default_nettype none
package trcc_pkg;

	// One access from the management port front end.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] cmd;
		logic [15:0] wdata;
	} trcc_req_s;

	// Answer to an access.
	typedef struct packed {
		logic ack;
		logic known;
		logic [15:0] rdata;
	} trcc_rsp_s;

	// Temperature regions, Gray coded from cold to hot.
	typedef enum logic [2:0] {
		TRCC_R1 = 3'h0,
		TRCC_R2 = 3'h1,
		TRCC_R3 = 3'h3,
		TRCC_R4 = 3'h2,
		TRCC_R5 = 3'h6,
		TRCC_R6 = 3'h7,
		TRCC_R7 = 3'h5
	} trcc_region_e;

	// Six boundaries, coldest first.
	typedef struct packed {
		logic signed [15:0] t1;
		logic signed [15:0] t2;
		logic signed [15:0] t3;
		logic signed [15:0] t4;
		logic signed [15:0] t5;
		logic signed [15:0] t6;
	} trcc_bounds_s;

	// Regional voltage and current codes.
	typedef struct packed {
		logic [4:0] v2;
		logic [4:0] v3;
		logic [4:0] v4;
		logic [4:0] v5;
		logic [4:0] v6;
		logic [4:0] i2;
		logic [4:0] i3;
		logic [4:0] i4;
		logic [4:0] i5;
		logic [4:0] i6;
	} trcc_codes_s;

	// Codes handed to the charger servo loops.
	typedef struct packed {
		logic [4:0] vcode;
		logic [4:0] icode;
		logic subst;
	} trcc_applied_s;

endpackage
`default_nettype wire

// >>> design/trcc_region_sel.sv
// Classifies the thermistor reading into one of seven temperature regions.
`default_nettype none
module trcc_region_sel #(
	parameter int READING_W = 16
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic signed [READING_W-1:0] reading,
	input wire trcc_pkg::trcc_bounds_s bounds,
	output logic [2:0] region
);

	typedef struct packed {
		trcc_pkg::trcc_region_e region;
	} trcc_rsel_state_s;

	trcc_rsel_state_s state_q;
	trcc_rsel_state_s state_d;

	generate
		if (READING_W != 16) begin : g_bad_width
			$error("trcc_region_sel: reading must be 16 bits wide");
		end
	endgenerate

	// The reading falls as temperature rises, so the colder region is the
	// one whose boundary the reading still exceeds.
	always_comb begin
		state_d = state_q;
		if (reading > bounds.t1) begin
			state_d.region = trcc_pkg::TRCC_R1;
		end else if (reading > bounds.t2) begin
			state_d.region = trcc_pkg::TRCC_R2;
		end else if (reading > bounds.t3) begin
			state_d.region = trcc_pkg::TRCC_R3;
		end else if (reading > bounds.t4) begin
			state_d.region = trcc_pkg::TRCC_R4;
		end else if (reading > bounds.t5) begin
			state_d.region = trcc_pkg::TRCC_R5;
		end else if (reading > bounds.t6) begin
			state_d.region = trcc_pkg::TRCC_R6;
		end else begin
			state_d.region = trcc_pkg::TRCC_R7;
		end
	end

	// Reset lands in region 1, where no regional code is substituted.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_q <= '{region: trcc_pkg::TRCC_R1};
		end else begin
			state_q <= state_d;
		end
	end

	assign region = state_q.region;

endmodule
`default_nettype wire

// >>> design/trcc_regs.sv
// Register bank and code selection for temperature-qualified charging.
`include "trcc_cfg.svh"
`default_nettype none

// Overview of operation
// - Boundary three at 0x21, signed, reset 7970.
// - Boundary four at 0x22, signed, reset 7112.
// - Boundary five at 0x23, signed, reset 6325.
// - Boundary six at 0x24, signed, reset 4970.
// - Boundaries descend from cold to warm.
// - 0x25 ten bits; region 6 voltage bits 9:5.
// - Region 5 voltage code in bits 4:0.
// - 0x26 packs region 4, 3, 2 voltage codes.
// - Voltage codes share base voltage encoding.
// - 0x27 ten bits; region 6 current bits 9:5.
// - Current codes share base current encoding.
// - Config bit 0 enables regions, resets one.
// - Region 5 current code in bits 4:0.
// - Current follows base unless thermal or region.
module trcc_regs #(
	parameter int READING_W = 16
) (
	input wire logic clock,
	input wire logic nrst,
	input wire trcc_pkg::trcc_req_s reg_req,
	output trcc_pkg::trcc_rsp_s reg_rsp,
	input wire logic signed [READING_W-1:0] thermistor_reading,
	input wire logic signed [15:0] region_boundary_one,
	input wire logic signed [15:0] region_boundary_two,
	input wire logic [14:0] cold_regions_current_codes,
	input wire logic [4:0] base_vcode,
	input wire logic [4:0] base_icode,
	input wire logic thermal_active,
	input wire logic [4:0] thermal_icode,
	output logic [2:0] active_region,
	output logic [2:0] charger_config,
	output logic [4:0] applied_vcode,
	output logic [4:0] applied_icode,
	output logic region_subst
);

	// Whole state of the bank, one flop group.
	typedef struct packed {
		logic signed [15:0] bound3;
		logic signed [15:0] bound4;
		logic signed [15:0] bound5;
		logic signed [15:0] bound6;
		logic [9:0] vwarm;
		logic [14:0] vmid;
		logic [9:0] iwarm;
		logic [2:0] cfg;
		trcc_pkg::trcc_rsp_s rsp;
	} trcc_regs_state_s;

	trcc_regs_state_s state_q;
	trcc_regs_state_s state_d;
	trcc_pkg::trcc_bounds_s bounds;
	trcc_pkg::trcc_codes_s codes;
	trcc_pkg::trcc_applied_s applied;
	logic [2:0] region;

	generate
		if (READING_W != 16) begin : g_bad_width
			$error("trcc_regs: thermistor reading must be 16 bits wide");
		end
	endgenerate

	// Pulls one five-bit code out of a packed code register.
	function automatic logic [4:0] trcc_field(input logic [14:0] word,
		input int lsb);
		logic [14:0] shifted;
		shifted = word >> lsb;
		trcc_field = shifted[4:0];
	endfunction

	// Known command codes of this bank.
	function automatic logic trcc_known(input logic [7:0] cmd);
		trcc_known = 1'b0;
		case (cmd)
			`TRCC_CMD_BOUND3,
			`TRCC_CMD_BOUND4,
			`TRCC_CMD_BOUND5,
			`TRCC_CMD_BOUND6,
			`TRCC_CMD_VWARM,
			`TRCC_CMD_VMID,
			`TRCC_CMD_IWARM,
			`TRCC_CMD_CFG: begin
				trcc_known = 1'b1;
			end
			default: begin
				trcc_known = 1'b0;
			end
		endcase
	endfunction

	// Accesses: a write stores the low field bits only, so upper bits
	// can never be set and always read back as zero. A read in the same
	// cycle as a write returns the value held before the write.
	always_comb begin
		state_d = state_q;
		state_d.rsp.ack = reg_req.wr || reg_req.rd;
		state_d.rsp.known = trcc_known(reg_req.cmd);
		state_d.rsp.rdata = '0;
		if (reg_req.rd) begin
			case (reg_req.cmd)
				`TRCC_CMD_BOUND3: begin
					state_d.rsp.rdata = state_q.bound3;
				end
				`TRCC_CMD_BOUND4: begin
					state_d.rsp.rdata = state_q.bound4;
				end
				`TRCC_CMD_BOUND5: begin
					state_d.rsp.rdata = state_q.bound5;
				end
				`TRCC_CMD_BOUND6: begin
					state_d.rsp.rdata = state_q.bound6;
				end
				`TRCC_CMD_VWARM: begin
					state_d.rsp.rdata = {6'h00, state_q.vwarm};
				end
				`TRCC_CMD_VMID: begin
					state_d.rsp.rdata = {1'h0, state_q.vmid};
				end
				`TRCC_CMD_IWARM: begin
					state_d.rsp.rdata = {6'h00, state_q.iwarm};
				end
				`TRCC_CMD_CFG: begin
					state_d.rsp.rdata = {13'h0000, state_q.cfg};
				end
				default: begin
					state_d.rsp.rdata = '0;
				end
			endcase
		end
		if (reg_req.wr) begin
			case (reg_req.cmd)
				`TRCC_CMD_BOUND3: begin
					state_d.bound3 = reg_req.wdata;
				end
				`TRCC_CMD_BOUND4: begin
					state_d.bound4 = reg_req.wdata;
				end
				`TRCC_CMD_BOUND5: begin
					state_d.bound5 = reg_req.wdata;
				end
				`TRCC_CMD_BOUND6: begin
					state_d.bound6 = reg_req.wdata;
				end
				`TRCC_CMD_VWARM: begin
					state_d.vwarm = reg_req.wdata[9:0];
				end
				`TRCC_CMD_VMID: begin
					state_d.vmid = reg_req.wdata[14:0];
				end
				`TRCC_CMD_IWARM: begin
					state_d.iwarm = reg_req.wdata[9:0];
				end
				`TRCC_CMD_CFG: begin
					state_d.cfg = reg_req.wdata[2:0];
				end
				default: begin
					state_d.cfg = state_q.cfg;
				end
			endcase
		end
	end

	// Synchronous reset loads the documented defaults.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_q.bound3 <= `TRCC_RST_BOUND3;
			state_q.bound4 <= `TRCC_RST_BOUND4;
			state_q.bound5 <= `TRCC_RST_BOUND5;
			state_q.bound6 <= `TRCC_RST_BOUND6;
			state_q.vwarm <= `TRCC_RST_VWARM;
			state_q.vmid <= `TRCC_RST_VMID;
			state_q.iwarm <= `TRCC_RST_IWARM;
			state_q.cfg <= `TRCC_RST_CFG;
			state_q.rsp <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// Boundaries are used as programmed; the bank does not reorder them,
	// so software must keep them descending or regions will be skipped.
	always_comb begin
		bounds.t1 = region_boundary_one;
		bounds.t2 = region_boundary_two;
		bounds.t3 = state_q.bound3;
		bounds.t4 = state_q.bound4;
		bounds.t5 = state_q.bound5;
		bounds.t6 = state_q.bound6;
	end

	// Unpack the regional codes. The codes keep the base encodings, so
	// they are passed to the servo loops without any translation.
	always_comb begin
		codes.v6 = trcc_field({5'h00, state_q.vwarm}, `TRCC_FLD_HI);
		codes.v5 = trcc_field({5'h00, state_q.vwarm}, `TRCC_FLD_LO);
		codes.v4 = trcc_field(state_q.vmid, `TRCC_FLD_TOP);
		codes.v3 = trcc_field(state_q.vmid, `TRCC_FLD_HI);
		codes.v2 = trcc_field(state_q.vmid, `TRCC_FLD_LO);
		codes.i6 = trcc_field({5'h00, state_q.iwarm}, `TRCC_FLD_HI);
		codes.i5 = trcc_field({5'h00, state_q.iwarm}, `TRCC_FLD_LO);
		codes.i4 = trcc_field(cold_regions_current_codes, `TRCC_FLD_TOP);
		codes.i3 = trcc_field(cold_regions_current_codes, `TRCC_FLD_HI);
		codes.i2 = trcc_field(cold_regions_current_codes,
			`TRCC_FLD_LO);
	end

	trcc_region_sel #(
		.READING_W(READING_W)
	) u_region_sel (
		.clock(clock),
		.nrst(nrst),
		.reading(thermistor_reading),
		.bounds(bounds),
		.region(region)
	);

	trcc_code_mux u_code_mux (
		.clock(clock),
		.nrst(nrst),
		.enable(state_q.cfg[`TRCC_CFG_EN_BIT]),
		.region(region),
		.codes(codes),
		.base_vcode(base_vcode),
		.base_icode(base_icode),
		.thermal_active(thermal_active),
		.thermal_icode(thermal_icode),
		.applied(applied)
	);

	// All outputs come straight from flops.
	assign reg_rsp = state_q.rsp;
	assign active_region = region;
	assign charger_config = state_q.cfg;
	assign applied_vcode = applied.vcode;
	assign applied_icode = applied.icode;
	assign region_subst = applied.subst;

endmodule
`default_nettype wire

// >>> tb/trcc_checker.sv
// Port assertions for the region configuration bank.
`default_nettype none
module trcc_checker #(
	parameter int READING_W = 16
) (
	input wire logic clock,
	input wire logic nrst,
	input wire trcc_pkg::trcc_req_s reg_req,
	input wire trcc_pkg::trcc_rsp_s reg_rsp,
	input wire logic signed [READING_W-1:0] thermistor_reading,
	input wire logic signed [15:0] region_boundary_one,
	input wire logic signed [15:0] region_boundary_two,
	input wire logic [4:0] base_vcode,
	input wire logic [4:0] base_icode,
	input wire logic thermal_active,
	input wire logic [2:0] active_region,
	input wire logic [2:0] charger_config,
	input wire logic [4:0] applied_vcode,
	input wire logic [4:0] applied_icode,
	input wire logic region_subst
);
	// One clock domain, so one clocking and one disable for all.
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	a_ack_follows: assert property ((reg_req.wr || reg_req.rd) |=> reg_rsp.ack)
		else $error("access not answered");
	a_ack_cause: assert property (reg_rsp.ack |-> $past(reg_req.wr || reg_req.rd))
		else $error("answer without access");
	a_bound_readback: assert property (
		(reg_req.wr && reg_req.cmd inside {[8'h21:8'h24]}) ##1
		(reg_req.rd && !reg_req.wr && reg_req.cmd == $past(reg_req.cmd))
		|=> reg_rsp.rdata == $past(reg_req.wdata, 2))
		else $error("boundary readback wrong");
	a_ten_bit_width: assert property (
		(reg_req.rd && reg_req.cmd inside {8'h25, 8'h27})
		|=> reg_rsp.rdata[15:10] == 6'h00)
		else $error("ten bit register shows high bits");
	a_vmid_width: assert property (
		(reg_req.rd && reg_req.cmd == 8'h26) |=> reg_rsp.rdata[15] == 1'b0)
		else $error("fifteen bit register shows bit 15");
	a_unknown_cmd: assert property (
		(reg_req.rd && !(reg_req.cmd inside {[8'h21:8'h27], 8'h29}))
		|=> !reg_rsp.known && reg_rsp.rdata == 16'h0000)
		else $error("unknown command answered");
	a_region_cold: assert property (
		(thermistor_reading > region_boundary_one) |=> active_region == 3'h0)
		else $error("coldest region not chosen");
	a_region_two: assert property (
		(thermistor_reading <= region_boundary_one &&
		thermistor_reading > region_boundary_two) |=> active_region == 3'h1)
		else $error("second region not chosen");
	a_cold_no_subst: assert property (
		active_region == 3'h0 |=> !region_subst)
		else $error("substitution in coldest region");
	a_off_base_volt: assert property (
		!charger_config[0] |=> applied_vcode == $past(base_vcode) && !region_subst)
		else $error("voltage not base while disabled");
	a_off_base_curr: assert property (
		(!charger_config[0] && !thermal_active)
		|=> applied_icode == $past(base_icode))
		else $error("current not base while disabled");
endmodule

bind trcc_regs trcc_checker #(.READING_W(READING_W)) trcc_checker_i (
	.clock(clock),
	.nrst(nrst),
	.reg_req(reg_req),
	.reg_rsp(reg_rsp),
	.thermistor_reading(thermistor_reading),
	.region_boundary_one(region_boundary_one),
	.region_boundary_two(region_boundary_two),
	.base_vcode(base_vcode),
	.base_icode(base_icode),
	.thermal_active(thermal_active),
	.active_region(active_region),
	.charger_config(charger_config),
	.applied_vcode(applied_vcode),
	.applied_icode(applied_icode),
	.region_subst(region_subst)
);
`default_nettype wire

// >>> tb/trcc_host.sv
// Behavioural host issuing accesses on the bank's command port.
`default_nettype none
module trcc_host (
	input wire logic clock,
	output var trcc_pkg::trcc_req_s req,
	input wire trcc_pkg::trcc_rsp_s rsp
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle lines at time zero.
	initial begin
		req = '0;
	end

	// Presented after a falling edge, taken at the next rising edge, answer
	// read at the falling edge after that. Idle lines carry inverted leftovers so that a
	// stale command can never pass for a fresh one.
	task automatic xfer(input logic w, input logic r, input logic [7:0] c,
		input logic [15:0] d, output trcc_pkg::trcc_rsp_s a);
		@(negedge clock);
		req = '{wr: w, rd: r, cmd: c, wdata: d};
		@(negedge clock);
		a = rsp;
		req = '{wr: 1'b0, rd: 1'b0, cmd: ~c, wdata: ~d};
	endtask
endmodule
`default_nettype wire

// >>> tb/trcc_regs_tb_top.sv
// Self-checking bench for the region configuration bank.
`include "trcc_cfg.svh"
`default_nettype none
module trcc_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [7:0] cmd;
		logic [15:0] rst;
		logic [15:0] mask;
	} trcc_row_s;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	trcc_pkg::trcc_req_s reg_req;
	trcc_pkg::trcc_rsp_s reg_rsp;
	trcc_pkg::trcc_rsp_s a;
	logic signed [15:0] reading = 16'h4E20;
	logic therm_on = 1'b0;
	logic [4:0] therm_code = 5'h1F;
	logic [2:0] region;
	logic [2:0] config_bits;
	logic [4:0] vcode;
	logic [4:0] icode;
	logic subst;
	int n_mismatch = 0;
	int check_count = 0;
	int cycles = 0;
	trcc_row_s rows [8] = '{
		'{`TRCC_CMD_BOUND3, `TRCC_RST_BOUND3, 16'hFFFF},
		'{`TRCC_CMD_BOUND4, `TRCC_RST_BOUND4, 16'hFFFF},
		'{`TRCC_CMD_BOUND5, `TRCC_RST_BOUND5, 16'hFFFF},
		'{`TRCC_CMD_BOUND6, `TRCC_RST_BOUND6, 16'hFFFF},
		'{`TRCC_CMD_VWARM, `TRCC_RST_VWARM, 16'h03FF},
		'{`TRCC_CMD_VMID, `TRCC_RST_VMID, 16'h7FFF},
		'{`TRCC_CMD_IWARM, `TRCC_RST_IWARM, 16'h03FF},
		'{`TRCC_CMD_CFG, `TRCC_RST_CFG, 16'h0007}
	};

	// Region boundaries one and two sit above the bank's default boundaries.
	trcc_regs trcc_regs_i (
		.clock(clock),
		.nrst(nrst),
		.reg_req(reg_req),
		.reg_rsp(reg_rsp),
		.thermistor_reading(reading),
		.region_boundary_one(16'h3E80),
		.region_boundary_two(16'h36B0),
		.cold_regions_current_codes(15'h1062),
		.base_vcode(5'h1F),
		.base_icode(5'h1E),
		.thermal_active(therm_on),
		.thermal_icode(therm_code),
		.active_region(region),
		.charger_config(config_bits),
		.applied_vcode(vcode),
		.applied_icode(icode),
		.region_subst(subst)
	);

	trcc_host trcc_host_i (
		.clock(clock),
		.req(reg_req),
		.rsp(reg_rsp)
	);

	// Clock and hang guard; the ceiling is far above the hundred or so cycles needed.
	always #10 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			conclude();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// New reading, then region and codes are looked at on the falling edge after two rising edges.
	task automatic zone(input logic [15:0] rd, input logic [2:0] er,
		input logic [4:0] ev, input logic [4:0] ei, input logic es);
		@(negedge clock);
		reading = rd;
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk({2'h0, region, vcode, icode, subst}, {2'h0, er, ev, ei, es});
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(negedge clock);
		nrst = 1'b1;
		repeat (2) @(negedge clock);
		// Reset value, all writable bits flipped, then the default restored.
		foreach (rows[k]) begin
			trcc_host_i.xfer(1'b0, 1'b1, rows[k].cmd, 16'h0000, a);
			chk(a.rdata, rows[k].rst);
			trcc_host_i.xfer(1'b1, 1'b0, rows[k].cmd, ~rows[k].rst, a);
			trcc_host_i.xfer(1'b0, 1'b1, rows[k].cmd, 16'h0000, a);
			chk(a.rdata, ~rows[k].rst & rows[k].mask);
			trcc_host_i.xfer(1'b1, 1'b0, rows[k].cmd, rows[k].rst, a);
		end
		// An unmapped command reads as zero and is not claimed.
		trcc_host_i.xfer(1'b0, 1'b1, 8'h28, 16'h0000, a);
		chk(a.rdata, 16'h0000);
		chk({15'h0, a.known}, 16'h0000);
		// Write and read together return the old value.
		trcc_host_i.xfer(1'b1, 1'b1, `TRCC_CMD_BOUND3, 16'h1234, a);
		chk(a.rdata, `TRCC_RST_BOUND3);
		trcc_host_i.xfer(1'b0, 1'b1, `TRCC_CMD_BOUND3, 16'h0000, a);
		chk(a.rdata, 16'h1234);
		trcc_host_i.xfer(1'b1, 1'b0, `TRCC_CMD_BOUND3, `TRCC_RST_BOUND3, a);
		// Walk from cold to hot; equal readings fall to the warmer side.
		zone(16'h4E20, 3'h0, 5'h1F, 5'h1E, 1'b0);
		zone(16'h3E80, 3'h1, 5'h0F, 5'h02, 1'b1);
		zone(16'h2710, 3'h3, 5'h0F, 5'h03, 1'b1);
		zone(16'h1F22, 3'h2, 5'h07, 5'h04, 1'b1);
		zone(16'h1B58, 3'h6, 5'h07, 5'h0F, 1'b1);
		zone(16'h1388, 3'h7, 5'h03, 5'h0F, 1'b1);
		zone(16'hFF9C, 3'h5, 5'h1F, 5'h1E, 1'b0);
		// Thermal regulation may only lower the regional current.
		@(negedge clock);
		therm_on = 1'b1;
		therm_code = 5'h01;
		zone(16'h1388, 3'h7, 5'h03, 5'h01, 1'b1);
		@(negedge clock);
		therm_on = 1'b0;
		trcc_host_i.xfer(1'b1, 1'b0, `TRCC_CMD_VWARM, 16'h0232, a);
		zone(16'h1388, 3'h7, 5'h11, 5'h0F, 1'b1);
		// Disabling the region system hands back the base codes.
		trcc_host_i.xfer(1'b1, 1'b0, `TRCC_CMD_CFG, 16'h0000, a);
		zone(16'h1388, 3'h7, 5'h1F, 5'h1E, 1'b0);
		conclude();
	end
endmodule
`default_nettype wire
